// >>> rtl/fopcs_pkg.sv
// Package of the formatter operation/control status block: register
// indices, field positions, reset values, state records.
// Assumes a 32-bit AHB-Lite register bus, one word per register index.
package fopcs_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] FOPCS_IDX_OPCS = 8'h7A;
	localparam logic [7:0] FOPCS_IDX_MIRROR_A = 8'h41;
	localparam logic [7:0] FOPCS_IDX_MIRROR_B = 8'h61;
	localparam logic [7:0] FOPCS_IDX_SYNC_PAT = 8'h7F;
	localparam int FOPCS_IDX_LSB = 2;
	localparam int FOPCS_IDX_MSB = 9;

	// ==========================================================
	// Field positions of the operation/control status register
	localparam int FOPCS_BIT_INDEX = 0;
	localparam int FOPCS_BIT_SECTOR = 1;
	localparam int FOPCS_BIT_DATA_EDGE = 2;
	localparam int FOPCS_BIT_SYNC = 3;
	localparam int FOPCS_BIT_SEARCH = 4;
	localparam int FOPCS_BIT_SUPPRESS = 5;
	localparam int FOPCS_BIT_INHIBIT = 7;

	// ==========================================================
	// Reset values
	localparam logic [7:0] FOPCS_RST_OPCS = 8'h00;
	localparam logic [7:0] FOPCS_RST_SYNC_PAT = 8'hA1;
	localparam logic [31:0] FOPCS_RST_RDATA = 32'h0000_0000;

	// ==========================================================
	// AHB encodings
	localparam logic [1:0] FOPCS_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] FOPCS_HTRANS_SEQ = 2'h3;
	localparam logic [2:0] FOPCS_HSIZE_WORD = 3'h2;
	localparam logic FOPCS_HRESP_OKAY = 1'b0;

	// ==========================================================
	// Deserializer
	localparam logic [2:0] FOPCS_BITS_LAST = 3'h7;

	// Software controls
	typedef struct packed {
		logic inhibit_carry;
		logic buffer_access_disable;
		logic search_buffer;
	} fopcs_ctrl_t;

	// Deserialized byte towards compare and ECC logic
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} fopcs_byte_t;

	// Sync hunt states
	typedef enum logic [0:0] {
		FOPCS_HUNT = 1'b0,
		FOPCS_LOCKED = 1'b1
	} fopcs_sync_state_t;

endpackage : fopcs_pkg

// >>> rtl/fopcs_event_flag.sv
// Sticky flag set on a rising edge of a qualified input, cleared by a strobe.
// Assumes the watched input is synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module fopcs_event_flag
	import fopcs_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic watch, // Watched signal
	input wire logic qualify, // Edge counts only while high
	input wire logic clear, // Clear strobe
	output logic flag // Sticky flag
);
	typedef struct packed {
		logic prev;
		logic flag;
	} fopcs_flag_state_t;

	fopcs_flag_state_t st_ff;
	fopcs_flag_state_t nxt_st;
	logic rise;

	// ==========================================================
	// Next state: a set in the clearing cycle wins
	always_comb begin
		nxt_st = st_ff;
		rise = watch & ~st_ff.prev & qualify;
		nxt_st.prev = watch;
		nxt_st.flag = rise | (st_ff.flag & ~clear);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flag = st_ff.flag;
endmodule : fopcs_event_flag
`default_nettype wire

// >>> rtl/fopcs_deser.sv
// Serial read data deserializer with sync-pattern hunt.
// Assumes one bit per cycle in which bit_strobe is high.
`timescale 1ns/1ps
`default_nettype none
module fopcs_deser
	import fopcs_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic read_gate, // Read window
	input wire logic bit_strobe, // Serial bit valid
	input wire logic serial_in, // Serial read data
	input wire logic [7:0] sync_pattern, // Pattern that marks sync
	output logic synced, // Locked to the stream
	output fopcs_byte_t rd_byte // Deserialized byte, valid one cycle
);
	typedef struct packed {
		fopcs_sync_state_t mode;
		logic [7:0] shift;
		logic [2:0] bitcnt;
		fopcs_byte_t out;
	} fopcs_deser_state_t;

	fopcs_deser_state_t st_ff;
	fopcs_deser_state_t nxt_st;
	logic [7:0] shifted;

	// ==========================================================
	// Hunt for the pattern, then frame bytes after it
	always_comb begin
		nxt_st = st_ff;
		shifted = {st_ff.shift[6:0], serial_in};
		nxt_st.out.valid = 1'b0;
		if (!read_gate) begin
			nxt_st.mode = FOPCS_HUNT;
			nxt_st.bitcnt = '0;
		end else if (bit_strobe) begin
			nxt_st.shift = shifted;
			case (st_ff.mode)
				FOPCS_HUNT: begin
					if (shifted == sync_pattern) begin
						nxt_st.mode = FOPCS_LOCKED;
						nxt_st.bitcnt = '0;
					end
				end
				FOPCS_LOCKED: begin
					nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
					if (st_ff.bitcnt == FOPCS_BITS_LAST) begin
						nxt_st.out.valid = 1'b1;
						nxt_st.out.data = shifted;
					end
				end
				default: nxt_st.mode = FOPCS_HUNT;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign synced = (st_ff.mode == FOPCS_LOCKED);
	assign rd_byte = st_ff.out;
endmodule : fopcs_deser
`default_nettype wire

// >>> rtl/fopcs_top.sv
// Formatter operation/control status register bank with its disk-side
// event capture, compare source selection and transfer gating.
// Assumes one AHB-Lite master, drive pins synchronous to hclk.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fopcs_top
	import fopcs_pkg::*;
(
	input wire logic hclk, // Clock, 125 MHz
	input wire logic hresetn, // Async reset, active low
	// AHB-Lite slave
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	// Drive side
	input wire logic index_pulse, // Index pulse from drive
	input wire logic sector_mark_pulse, // Sector or address-mark pulse
	input wire logic read_gate, // Read window
	input wire logic nrz_bit_strobe, // Serial bit valid
	input wire logic nrz_read_data, // Serial read data
	// Sequencer side
	input wire logic seq_write_op, // Write operation active
	input wire logic [7:0] control_store_pattern, // Sequencer data field
	input wire logic [7:0] buf_rd_data, // Byte read from buffer
	input wire logic seq_buf_req, // Sequencer wants a buffer access
	input wire logic seq_count_carry, // Count field carry request
	input wire logic seq_count_load, // Count field load request
	output logic buf_req, // Buffer access request
	output logic [7:0] wr_serial_byte, // Byte to serialize on write
	output logic [7:0] buf_wr_data, // Byte to store in buffer
	output logic buf_wr_en, // Store strobe, one cycle
	output logic [7:0] ecc_byte, // Byte to ECC checker
	output logic ecc_byte_valid, // ECC byte strobe, one cycle
	output logic compare_equal, // Read byte equals reference
	output logic compare_high, // Read byte above reference
	output logic compare_low, // Read byte below reference
	output logic compare_valid, // Compare result strobe
	output logic count_carry_en, // Carry to the count field
	output logic count_load_en, // Load of the count field
	output logic [1:0] irq_status_mirror // Index and sector bits for interrupt status
);
	// ==========================================================
	// State
	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		fopcs_ctrl_t ctrl;
		logic [7:0] sync_pat;
		logic [7:0] wr_byte;
		logic [7:0] st_byte;
		logic st_en;
		logic [7:0] ecc_b;
		logic ecc_v;
		logic cmp_eq;
		logic cmp_hi;
		logic cmp_lo;
		logic cmp_v;
	} fopcs_top_state_t;

	fopcs_top_state_t st_ff;
	fopcs_top_state_t nxt_st;

	logic flag_index;
	logic flag_sector;
	logic flag_edge;
	logic synced;
	fopcs_byte_t rd_byte;
	logic addr_phase;
	logic [7:0] idx;
	logic rd_opcs;
	logic [7:0] opcs_view;
	logic [7:0] ref_byte;

	// ==========================================================
	// Bus decode
	assign addr_phase = hsel & hready & (htrans == FOPCS_HTRANS_NONSEQ || htrans == FOPCS_HTRANS_SEQ);
	assign idx = haddr[FOPCS_IDX_MSB:FOPCS_IDX_LSB];
	assign rd_opcs = addr_phase & ~hwrite & (idx == FOPCS_IDX_OPCS) & (haddr[31:10] == 22'h0);

	// ==========================================================
	// Event flags
	fopcs_event_flag u_flag_index (
		.hclk(hclk),
		.hresetn(hresetn),
		.watch(index_pulse),
		.qualify(1'b1),
		.clear(rd_opcs),
		.flag(flag_index)
	);

	fopcs_event_flag u_flag_sector (
		.hclk(hclk),
		.hresetn(hresetn),
		.watch(sector_mark_pulse),
		.qualify(1'b1),
		.clear(rd_opcs),
		.flag(flag_sector)
	);

	// A bit sampled without a strobe still counts; edges are seen on the pin
	fopcs_event_flag u_flag_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.watch(nrz_read_data),
		.qualify(read_gate),
		.clear(rd_opcs),
		.flag(flag_edge)
	);

	fopcs_deser u_deser (
		.hclk(hclk),
		.hresetn(hresetn),
		.read_gate(read_gate),
		.bit_strobe(nrz_bit_strobe),
		.serial_in(nrz_read_data),
		.sync_pattern(st_ff.sync_pat),
		.synced(synced),
		.rd_byte(rd_byte)
	);

	// ==========================================================
	// Register view
	always_comb begin
		opcs_view = 8'h00;
		opcs_view[FOPCS_BIT_INDEX] = flag_index;
		opcs_view[FOPCS_BIT_SECTOR] = flag_sector;
		opcs_view[FOPCS_BIT_DATA_EDGE] = flag_edge;
		opcs_view[FOPCS_BIT_SYNC] = synced;
		opcs_view[FOPCS_BIT_SEARCH] = st_ff.ctrl.search_buffer;
		opcs_view[FOPCS_BIT_SUPPRESS] = st_ff.ctrl.buffer_access_disable;
		opcs_view[FOPCS_BIT_INHIBIT] = st_ff.ctrl.inhibit_carry;
	end

	// Compare reference source
	assign ref_byte = st_ff.ctrl.search_buffer ? buf_rd_data : control_store_pattern;

	// ==========================================================
	// Next state
	always_comb begin
		nxt_st = st_ff;

		// Read data is captured at the address phase for the data phase
		if (addr_phase && !hwrite) begin
			if (haddr[31:10] != 22'h0) begin
				nxt_st.rdata = 32'h0000_0000;
			end else if (idx == FOPCS_IDX_OPCS) begin
				nxt_st.rdata = {24'h00_0000, opcs_view};
			end else if (idx == FOPCS_IDX_MIRROR_A || idx == FOPCS_IDX_MIRROR_B) begin
				nxt_st.rdata = {30'h0000_0000, flag_sector, flag_index};
			end else if (idx == FOPCS_IDX_SYNC_PAT) begin
				nxt_st.rdata = {24'h00_0000, st_ff.sync_pat};
			end else begin
				nxt_st.rdata = 32'h0000_0000;
			end
		end

		// Write data arrives in the data phase
		if (st_ff.wr_pend) begin
			if (st_ff.wr_idx == FOPCS_IDX_OPCS) begin
				nxt_st.ctrl.search_buffer = hwdata[FOPCS_BIT_SEARCH];
				nxt_st.ctrl.buffer_access_disable = hwdata[FOPCS_BIT_SUPPRESS];
				nxt_st.ctrl.inhibit_carry = hwdata[FOPCS_BIT_INHIBIT];
			end else if (st_ff.wr_idx == FOPCS_IDX_SYNC_PAT) begin
				nxt_st.sync_pat = hwdata[7:0];
			end
		end
		nxt_st.wr_pend = addr_phase & hwrite & (haddr[31:10] == 22'h0);
		nxt_st.wr_idx = idx;

		// Serial write source
		if (st_ff.ctrl.buffer_access_disable) begin
			nxt_st.wr_byte = control_store_pattern;
		end else begin
			nxt_st.wr_byte = buf_rd_data;
		end

		// Read path: outside a write operation ECC always sees the byte, the buffer only when allowed
		nxt_st.ecc_v = rd_byte.valid & ~seq_write_op;
		nxt_st.ecc_b = rd_byte.data;
		nxt_st.st_en = rd_byte.valid & ~seq_write_op & ~st_ff.ctrl.buffer_access_disable;
		nxt_st.st_byte = rd_byte.data;

		// Compare on each framed byte
		nxt_st.cmp_v = rd_byte.valid;
		if (rd_byte.valid) begin
			nxt_st.cmp_eq = (rd_byte.data == ref_byte);
			nxt_st.cmp_hi = (rd_byte.data > ref_byte);
			nxt_st.cmp_lo = (rd_byte.data < ref_byte);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.rdata <= FOPCS_RST_RDATA;
			st_ff.ctrl <= fopcs_ctrl_t'({FOPCS_RST_OPCS[FOPCS_BIT_INHIBIT], FOPCS_RST_OPCS[FOPCS_BIT_SUPPRESS],
				FOPCS_RST_OPCS[FOPCS_BIT_SEARCH]});
			st_ff.sync_pat <= FOPCS_RST_SYNC_PAT;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign hrdata = st_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp = FOPCS_HRESP_OKAY;

	assign buf_req = seq_buf_req & ~st_ff.ctrl.buffer_access_disable;
	assign wr_serial_byte = st_ff.wr_byte;
	assign buf_wr_data = st_ff.st_byte;
	assign buf_wr_en = st_ff.st_en;
	assign ecc_byte = st_ff.ecc_b;
	assign ecc_byte_valid = st_ff.ecc_v;
	assign compare_equal = st_ff.cmp_eq;
	assign compare_high = st_ff.cmp_hi;
	assign compare_low = st_ff.cmp_lo;
	assign compare_valid = st_ff.cmp_v;

	assign count_carry_en = seq_count_carry & ~st_ff.ctrl.inhibit_carry;
	assign count_load_en = seq_count_load & ~st_ff.ctrl.inhibit_carry;

	assign irq_status_mirror = {flag_sector, flag_index};

	// Bit 2 may be set again right after a read; software polls it to clear
endmodule : fopcs_top
`default_nettype wire

// >>> tb/fopcs_top_props.sv
// Port checker of the operation/control status block.
// Assumes it is bound onto fopcs_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fopcs_top_props
	import fopcs_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic index_pulse, // Index
	input wire logic sector_mark_pulse, // Sector mark
	input wire logic seq_buf_req, // Request in
	input wire logic seq_count_carry, // Carry in
	input wire logic seq_count_load, // Load in
	input wire logic buf_req, // Request out
	input wire logic buf_wr_en, // Store strobe
	input wire logic [7:0] buf_wr_data, // Store byte
	input wire logic [7:0] ecc_byte, // ECC byte
	input wire logic ecc_byte_valid, // ECC strobe
	input wire logic compare_equal, // Equal
	input wire logic compare_high, // High
	input wire logic compare_low, // Low
	input wire logic compare_valid, // Compare strobe
	input wire logic count_carry_en, // Carry out
	input wire logic count_load_en, // Load out
	input wire logic [1:0] irq_status_mirror // Mirror
);
	// ==========================================================
	// Relations between ports
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_opcs;
	assign rd_opcs = hsel && htrans[1] && !hwrite && haddr == {22'h0, FOPCS_IDX_OPCS, 2'h0};
	a_index_sets: assert property ($rose(index_pulse) |=> irq_status_mirror[0]) else $error("index flag not set");
	a_sector_sets: assert property ($rose(sector_mark_pulse) |=> irq_status_mirror[1]) else $error("sector flag not set");
	a_index_holds: assert property ($fell(irq_status_mirror[0]) |-> $past(rd_opcs)) else $error("index flag lost");
	a_sector_holds: assert property ($fell(irq_status_mirror[1]) |-> $past(rd_opcs)) else $error("sector flag lost");
	a_count_gate: assert property ((count_carry_en |-> seq_count_carry) and (count_load_en |-> seq_count_load))
		else $error("count enable without request");
	a_buf_gate: assert property (buf_req |-> seq_buf_req) else $error("buffer request invented");
	a_store_ecc: assert property (buf_wr_en |-> ecc_byte_valid && buf_wr_data == ecc_byte) else $error("store apart");
	a_cmp_onehot: assert property (compare_valid |-> $onehot({compare_equal, compare_high, compare_low}))
		else $error("compare result not one-hot");
endmodule : fopcs_top_props
bind fopcs_top fopcs_top_props props_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .index_pulse,
	.sector_mark_pulse, .seq_buf_req, .seq_count_carry, .seq_count_load, .buf_req, .buf_wr_en, .buf_wr_data,
	.ecc_byte, .ecc_byte_valid, .compare_equal, .compare_high, .compare_low, .compare_valid, .count_carry_en,
	.count_load_en, .irq_status_mirror);
`default_nettype wire

// >>> tb/fopcs_drive_model.sv
// Disk drive model: index and sector pulses, read window, serial data.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fopcs_drive_model (
	input wire logic hclk, // Clock
	output logic index_pulse, // Index
	output logic sector_mark_pulse, // Sector mark
	output logic read_gate, // Read window
	output logic nrz_bit_strobe, // Bit strobe
	output logic nrz_read_data // Serial data
);
	// ==========================================================
	// Drive behaviour
	initial begin
		index_pulse = 1'h0;
		sector_mark_pulse = 1'h0;
		read_gate = 1'h0;
		nrz_bit_strobe = 1'h0;
		nrz_read_data = 1'h0;
	end
	task pulse(input int which);
		@(posedge hclk);
		if (which == 0) index_pulse <= 1'h1;
		else sector_mark_pulse <= 1'h1;
		repeat (3) @(posedge hclk);
		index_pulse <= 1'h0;
		sector_mark_pulse <= 1'h0;
	endtask : pulse
	task gate(input logic g);
		@(posedge hclk);
		read_gate <= g;
	endtask : gate
	// Bits go MSB first; afterwards the line shows the inverse of the last bit
	task send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge hclk);
			nrz_read_data <= b[i];
			nrz_bit_strobe <= 1'h1;
			@(posedge hclk);
			nrz_bit_strobe <= 1'h0;
		end
		nrz_read_data <= ~b[0];
	endtask : send_byte
endmodule : fopcs_drive_model
`default_nettype wire

// >>> tb/fopcs_top_tb.sv
// Testbench of the operation/control status block.
// Assumes the drive model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module fopcs_top_tb;
	import fopcs_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, seq_write_op, seq_buf_req, seq_count_carry, seq_count_load;
	logic index_pulse, sector_mark_pulse, read_gate, nrz_bit_strobe, nrz_read_data, buf_req, buf_wr_en;
	logic ecc_byte_valid, compare_equal, compare_high, compare_low, compare_valid, count_carry_en, count_load_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, irq_status_mirror;
	logic [2:0] hsize, last_cmp;
	logic [7:0] control_store_pattern, buf_rd_data, wr_serial_byte, buf_wr_data, ecc_byte, last_ecc;
	logic [17:0] rows [5] = '{18'h00003, 18'h08081, 18'h20202, 18'h3FEC0, 18'h04043};
	int n_errors, checks_done, cyc, n_ecc, n_wr, k;
	fopcs_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .index_pulse, .sector_mark_pulse, .read_gate, .nrz_bit_strobe, .nrz_read_data,
		.seq_write_op, .control_store_pattern, .buf_rd_data, .seq_buf_req, .seq_count_carry, .seq_count_load,
		.buf_req, .wr_serial_byte, .buf_wr_data, .buf_wr_en, .ecc_byte, .ecc_byte_valid, .compare_equal,
		.compare_high, .compare_low, .compare_valid, .count_carry_en, .count_load_en, .irq_status_mirror);
	fopcs_drive_model drv_u (.hclk, .index_pulse, .sector_mark_pulse, .read_gate, .nrz_bit_strobe, .nrz_read_data);
	// ==========================================================
	// Clock, monitor, tasks
	initial begin
		hclk = 1'h0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (ecc_byte_valid === 1'h1) begin
			n_ecc <= n_ecc + 1;
			last_ecc <= ecc_byte;
		end
		if (buf_wr_en === 1'h1) n_wr <= n_wr + 1;
		if (compare_valid === 1'h1) last_cmp <= {compare_equal, compare_high, compare_low};
		if (cyc == 5000) begin
			n_errors++;
			conclude();
		end
	end
	task conclude;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= FOPCS_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb
	task byte_in(input logic [7:0] b);
		drv_u.send_byte(b);
		repeat (3) @(posedge hclk);
	endtask : byte_in
	// ==========================================================
	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, seq_write_op, haddr, hwdata, htrans, last_cmp, last_ecc} = '0;
		{seq_buf_req, seq_count_carry, seq_count_load} = 3'h7;
		hsize = FOPCS_HSIZE_WORD;
		control_store_pattern = 8'h5A;
		buf_rd_data = 8'h10;
		{n_errors, checks_done, cyc, n_ecc, n_wr} = '0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, 32'h1E8, 32'h0);
		chk(rd, 32'h0);
		chk({hresp, hreadyout}, {FOPCS_HRESP_OKAY, 1'h1});
		ahb(1'h0, 32'h1FC, 32'h0);
		chk(rd, 32'hA1);
		ahb(1'h1, 32'h0, 32'hFF);
		ahb(1'h0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		for (k = 0; k < 5; k++) begin
			ahb(1'h1, 32'h1E8, {24'h0, rows[k][17:10]});
			ahb(1'h0, 32'h1E8, 32'h0);
			chk(rd, {24'h0, rows[k][9:2]});
			chk({buf_req, count_carry_en, count_load_en}, {rows[k][1], rows[k][0], rows[k][0]});
		end
		for (k = 0; k < 2; k++) begin
			drv_u.pulse(k);
			chk(irq_status_mirror, 2'h1 << k);
			ahb(1'h0, 32'h104, 32'h0);
			ahb(1'h0, 32'h184, 32'h0);
			chk(rd, 32'h1 << k);
			ahb(1'h0, 32'h1E8, 32'h0);
			chk(rd, 32'h10 | (32'h1 << k));
			ahb(1'h0, 32'h1E8, 32'h0);
			chk(rd, 32'h10);
		end
		drv_u.gate(1'h1);
		byte_in(8'hA1);
		ahb(1'h0, 32'h1E8, 32'h0);
		chk(rd, 32'h1C);
		k = 0;
		do begin
			ahb(1'h0, 32'h1E8, 32'h0);
			k++;
		end while (rd[2] !== 1'h0 && k < 4);
		chk(rd, 32'h18);
		byte_in(8'h20);
		chk({last_cmp, last_ecc, n_wr[7:0]}, {3'h2, 8'h20, 8'h1});
		ahb(1'h1, 32'h1E8, 32'h0);
		byte_in(8'h5A);
		chk(last_cmp, 3'h4);
		ahb(1'h1, 32'h1E8, 32'h20);
		byte_in(8'h33);
		chk({last_ecc, n_ecc[7:0], n_wr[7:0], buf_req}, {8'h33, 8'h3, 8'h2, 1'h0});
		seq_write_op <= 1'h1;
		repeat (3) @(posedge hclk);
		chk(wr_serial_byte, 8'h5A);
		ahb(1'h1, 32'h1E8, 32'h0);
		repeat (3) @(posedge hclk);
		chk(wr_serial_byte, 8'h10);
		drv_u.gate(1'h0);
		ahb(1'h0, 32'h1E8, 32'h0);
		chk(rd & 32'h8, 32'h0);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		ahb(1'h0, 32'h1E8, 32'h0);
		chk(rd, 32'h0);
		conclude();
	end
endmodule : fopcs_top_tb
`default_nettype wire
